// ---- hw/irq_flag_enable_slice.sv ----
// pending flag and enable slice of the interrupt controller, AHB-Lite slave
//
// Added by the designer: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`include "irq_slice_defines.svh"

// --------------------------------------------------------------------
// register map, one aligned word each, data in bits 15:0
// --------------------------------------------------------------------
// 0x00 pending group 4, read/write, hardware sets
// 0x04 pending group 5, read/write, hardware sets
// 0x08 pending group 6, read/write, hardware sets
// 0x0c enable group 0, plain storage, exported on its port
// 0x10 enables of the group 4 sources
// 0x14 enables of the group 5 sources
// 0x18 enables of the group 6 sources
// 0x1c sticky group events, read only
// 0x20 event clear, a one clears, reads zero
// 0x24 event enables, feed the irq line
// other words read zero and ignore writes
// zero wait states, response always okay

// What this block does
// - hardware sets flags; software reads, writes them
// - flag one means request recorded
// - all flags and enables reset to zero
// - unassigned bit positions always read zero
// - group 4 bit 8 low voltage
// - group 4 bit 3 checksum, 7-4 zero
// - group 4 bits 1,2 serial errors
// - group 5 capture 13, compare 12
// - group 5 bits 11,10 sync serial
// - group 5 serial d bits 9,8,7
// - group 5 bit 6 otg controller
// - group 5 two wire bits 5,4
// - group 5 serial c bits 3,2,1
// - group 6 only graphics bit 4
// - enable gates request, flag untouched
module irq_flag_enable_slice
  import irq_slice_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire grp_word_t   src_set,
  output grp_word_t        src_req,
  output logic [15:0]      enable_group0,
  output logic             irq
);

  // --------------------------------------------------------------------
  // state and next state
  // --------------------------------------------------------------------
  slice_state_t st;        // registered state
  slice_state_t next_st;   // combinational next state

  logic       addr_phase;  // valid address phase this cycle
  logic [2:0] grp_evt;     // a hardware set in a group
  logic [2:0] evt_clr;     // software clear of events

  // implemented-bit masks
  localparam logic [15:0] M4  = `MASK_GROUP4;
  localparam logic [15:0] M5  = `MASK_GROUP5;
  localparam logic [15:0] M6  = `MASK_GROUP6;
  localparam logic [15:0] ME0 = `MASK_ENABLE_GROUP0;

  // --------------------------------------------------------------------
  // next-state logic
  // --------------------------------------------------------------------
  always_comb
  begin
    // defaults: hold state, no group event, no clears
    next_st    = st;
    addr_phase = hsel && hready && htrans[1];
    grp_evt    = '0;
    evt_clr    = '0;
    // hardware sets, masked to implemented bits
    grp_evt[0] = |(src_set.g4 & M4);
    grp_evt[1] = |(src_set.g5 & M5);
    grp_evt[2] = |(src_set.g6 & M6);
    // data phase of a write
    if (st.wr_pend)
    begin
      unique case (st.wr_addr)
        `OFF_PENDING_GROUP4: next_st.pend.g4 = hwdata[15:0];
        `OFF_PENDING_GROUP5: next_st.pend.g5 = hwdata[15:0];
        `OFF_PENDING_GROUP6: next_st.pend.g6 = hwdata[15:0];
        `OFF_ENABLE_GROUP0:  next_st.en0     = hwdata[15:0];
        `OFF_ENABLE_GROUP4:  next_st.en.g4   = hwdata[15:0];
        `OFF_ENABLE_GROUP5:  next_st.en.g5   = hwdata[15:0];
        `OFF_ENABLE_GROUP6:  next_st.en.g6   = hwdata[15:0];
        `OFF_EVT_CLEAR:      evt_clr         = hwdata[2:0];
        `OFF_EVT_ENABLE:     next_st.evt_en  = hwdata[2:0];
        default:             next_st.evt_en  = st.evt_en;      // read-only or unmapped
      endcase
    end
    // hardware set wins over a software clear: the write is applied
    // first and the pulses are or-ed in after it, so a request that
    // arrives together with a clear of the same flag is never lost
    next_st.pend.g4 = (next_st.pend.g4 | src_set.g4) & M4;
    next_st.pend.g5 = (next_st.pend.g5 | src_set.g5) & M5;
    next_st.pend.g6 = (next_st.pend.g6 | src_set.g6) & M6;
    next_st.en.g4   = next_st.en.g4 & M4;
    next_st.en.g5   = next_st.en.g5 & M5;
    next_st.en.g6   = next_st.en.g6 & M6;
    next_st.en0     = next_st.en0 & ME0;
    // one status bit per group, so a single read tells where to look
    // sticky events, set wins over clear
    next_st.evt_st  = (st.evt_st & ~evt_clr) | grp_evt;
    next_st.irq     = |(next_st.evt_st & next_st.evt_en);
    // per-source requests, enable gates without touching flag
    next_st.req.g4  = next_st.pend.g4 & next_st.en.g4;
    next_st.req.g5  = next_st.pend.g5 & next_st.en.g5;
    next_st.req.g6  = next_st.pend.g6 & next_st.en.g6;
    // only haddr[7:0] is decoded, upper address bits alias
    // zero wait states: ready high and okay on every cycle
    // address phase capture
    next_st.wr_pend = addr_phase && hwrite;
    next_st.wr_addr = haddr[7:0];
    next_st.hreadyout = 1'b1;
    next_st.hresp   = 1'b0;
    // read data for the coming data phase, sees any write in flight
    if (addr_phase && !hwrite)
    begin
      unique case (haddr[7:0])
        `OFF_PENDING_GROUP4: next_st.hrdata = {16'h0000, next_st.pend.g4};
        `OFF_PENDING_GROUP5: next_st.hrdata = {16'h0000, next_st.pend.g5};
        `OFF_PENDING_GROUP6: next_st.hrdata = {16'h0000, next_st.pend.g6};
        `OFF_ENABLE_GROUP0:  next_st.hrdata = {16'h0000, next_st.en0};
        `OFF_ENABLE_GROUP4:  next_st.hrdata = {16'h0000, next_st.en.g4};
        `OFF_ENABLE_GROUP5:  next_st.hrdata = {16'h0000, next_st.en.g5};
        `OFF_ENABLE_GROUP6:  next_st.hrdata = {16'h0000, next_st.en.g6};
        `OFF_EVT_STATUS:     next_st.hrdata = {29'h0000000, next_st.evt_st};
        `OFF_EVT_ENABLE:     next_st.hrdata = {29'h0000000, next_st.evt_en};
        default:             next_st.hrdata = 32'h0000_0000;   // unmapped, clear reg
      endcase
    end
    else
    begin
      next_st.hrdata = 32'h0000_0000;
    end
  end

  // --------------------------------------------------------------------
  // state register
  // --------------------------------------------------------------------
  // async reset clears flags, enables and events;
  // ready stays high so a master is never stalled by reset
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st           <= '0;
      st.hreadyout <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  // --------------------------------------------------------------------
  // outputs, straight from flops
  // --------------------------------------------------------------------
  assign hrdata        = st.hrdata;
  assign hreadyout     = st.hreadyout;
  assign hresp         = st.hresp;
  assign src_req       = st.req;
  assign enable_group0 = st.en0;
  assign irq           = st.irq;

  // --------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------
  logic        rd_dphase;   // read data phase in progress
  logic [7:0]  rd_addr;     // address of that read

  // helper: track read data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rd_dphase <= 1'b0;
      rd_addr   <= 8'h00;
    end
    else
    begin
      rd_dphase <= addr_phase && !hwrite;
      rd_addr   <= haddr[7:0];
    end
  end

  property p_hw_set;
    @(posedge hclk) disable iff (!hresetn)
    src_set.g5[`BIT_OTG_CONTROLLER_PENDING] |=> st.pend.g5[`BIT_OTG_CONTROLLER_PENDING];
  endproperty
  a_hw_set: assert property (p_hw_set) else $error("hw set did not land");

  property p_sw_clear;
    @(posedge hclk) disable iff (!hresetn)
    (st.wr_pend && st.wr_addr == `OFF_PENDING_GROUP4 && hwdata[`BIT_LOW_VOLTAGE_PENDING] == 1'b0
      && !src_set.g4[`BIT_LOW_VOLTAGE_PENDING]) |=> !st.pend.g4[`BIT_LOW_VOLTAGE_PENDING];
  endproperty
  a_sw_clear: assert property (p_sw_clear) else $error("software clear failed");

  property p_flag_cause;
    @(posedge hclk) disable iff (!hresetn)
    $rose(st.pend.g4[`BIT_CHECKSUM_GEN_PENDING]) |->
      ($past(src_set.g4[`BIT_CHECKSUM_GEN_PENDING]) || $past(st.wr_pend));
  endproperty
  a_flag_cause: assert property (p_flag_cause) else $error("flag rose with no cause");

  property p_reset_zero;
    @(posedge hclk) disable iff (!hresetn)
    $rose(hresetn) |-> (st.pend == '0 && st.en == '0 && st.en0 == 16'h0000 && !st.irq);
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("state not zero after reset");

  property p_unimpl_zero;
    @(posedge hclk) disable iff (!hresetn)
    ((st.pend.g4 & ~M4) == 16'h0000) && ((st.pend.g5 & ~M5) == 16'h0000)
      && ((st.pend.g6 & ~M6) == 16'h0000) && ((st.en0 & ~ME0) == 16'h0000);
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented bit set");

  property p_read_g4;
    @(posedge hclk) disable iff (!hresetn)
    (rd_dphase && rd_addr == `OFF_PENDING_GROUP4) |-> (hrdata[7:4] == 4'h0 && hrdata[31:9] == 23'h0);
  endproperty
  a_read_g4: assert property (p_read_g4) else $error("group 4 reserved bits read nonzero");

  property p_read_g5;
    @(posedge hclk) disable iff (!hresetn)
    (rd_dphase && rd_addr == `OFF_PENDING_GROUP5) |-> (hrdata[15:14] == 2'h0 && hrdata[0] == 1'b0);
  endproperty
  a_read_g5: assert property (p_read_g5) else $error("group 5 reserved bits read nonzero");

  property p_en_keeps_flag;
    @(posedge hclk) disable iff (!hresetn)
    (st.pend.g5[`BIT_SERIAL_D_RX_PENDING] && !st.wr_pend) ##1 !st.wr_pend
      |-> st.pend.g5[`BIT_SERIAL_D_RX_PENDING] && (src_req.g5[`BIT_SERIAL_D_RX_PENDING] ==
      st.en.g5[`BIT_SERIAL_D_RX_PENDING]);
  endproperty
  a_en_keeps_flag: assert property (p_en_keeps_flag) else $error("enable altered flag");

  property p_req_and;
    @(posedge hclk) disable iff (!hresetn)
    ##1 (src_req.g5 == (st.pend.g5 & st.en.g5)) && (src_req.g4 == (st.pend.g4 & st.en.g4))
      && (src_req.g6 == (st.pend.g6 & st.en.g6));
  endproperty
  a_req_and: assert property (p_req_and) else $error("request not flag and enable");

  property p_irq_level;
    @(posedge hclk) disable iff (!hresetn)
    irq == |(st.evt_st & st.evt_en);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq does not follow status");

  // --------------------------------------------------------------------
  // bus and register checks
  // --------------------------------------------------------------------
  property p_ready_okay;
    @(posedge hclk) disable iff (!hresetn)
    hreadyout && !hresp;
  endproperty
  a_ready_okay: assert property (p_ready_okay) else $error("slave stalled or answered an error");

  property p_rdata_idle;
    @(posedge hclk) disable iff (!hresetn)
    !rd_dphase |-> (hrdata == 32'h0000_0000);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside a read data phase");

  property p_read_g6;
    @(posedge hclk) disable iff (!hresetn)
    (rd_dphase && rd_addr == `OFF_PENDING_GROUP6) |-> (hrdata[31:5] == 27'h0 && hrdata[3:0] == 4'h0);
  endproperty
  a_read_g6: assert property (p_read_g6) else $error("group 6 reserved bits read nonzero");

  property p_read_en0;
    @(posedge hclk) disable iff (!hresetn)
    (rd_dphase && rd_addr == `OFF_ENABLE_GROUP0) |-> (hrdata[31:14] == 18'h0 && hrdata[4] == 1'b0);
  endproperty
  a_read_en0: assert property (p_read_en0) else $error("enable group 0 reserved bits read nonzero");

  property p_read_en4;
    @(posedge hclk) disable iff (!hresetn)
    (rd_dphase && rd_addr == `OFF_ENABLE_GROUP4)
      |-> (hrdata[31:9] == 23'h0 && hrdata[7:4] == 4'h0 && !hrdata[0]);
  endproperty
  a_read_en4: assert property (p_read_en4) else $error("enable group 4 reserved bits read nonzero");

  property p_clear_word_zero;
    @(posedge hclk) disable iff (!hresetn)
    (rd_dphase && rd_addr == `OFF_EVT_CLEAR) |-> (hrdata == 32'h0000_0000);
  endproperty
  a_clear_word_zero: assert property (p_clear_word_zero) else $error("clear word read nonzero");

  property p_write_lands;
    @(posedge hclk) disable iff (!hresetn)
    (st.wr_pend && st.wr_addr == `OFF_PENDING_GROUP5 && src_set.g5 == 16'h0000)
      |=> ({16'h0000, st.pend.g5} == ($past(hwdata) & {16'h0000, M5}));
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("software write to group 5 lost");

  property p_en0_write;
    @(posedge hclk) disable iff (!hresetn)
    (st.wr_pend && st.wr_addr == `OFF_ENABLE_GROUP0)
      |=> ({16'h0000, enable_group0} == ($past(hwdata) & {16'h0000, ME0}));
  endproperty
  a_en0_write: assert property (p_en0_write) else $error("enable group 0 write lost");

  property p_hw_set_lv;
    @(posedge hclk) disable iff (!hresetn)
    src_set.g4[`BIT_LOW_VOLTAGE_PENDING] |=> st.pend.g4[`BIT_LOW_VOLTAGE_PENDING];
  endproperty
  a_hw_set_lv: assert property (p_hw_set_lv) else $error("low voltage set did not land");

  property p_hw_set_crc;
    @(posedge hclk) disable iff (!hresetn)
    src_set.g4[`BIT_CHECKSUM_GEN_PENDING] |=> st.pend.g4[`BIT_CHECKSUM_GEN_PENDING];
  endproperty
  a_hw_set_crc: assert property (p_hw_set_crc) else $error("checksum set did not land");

  property p_hw_set_ser_a;
    @(posedge hclk) disable iff (!hresetn)
    src_set.g4[`BIT_SERIAL_A_ERROR_PENDING] |=> st.pend.g4[`BIT_SERIAL_A_ERROR_PENDING];
  endproperty
  a_hw_set_ser_a: assert property (p_hw_set_ser_a) else $error("serial a error set did not land");

  property p_hw_set_gfx;
    @(posedge hclk) disable iff (!hresetn)
    src_set.g6[`BIT_GRAPHICS_ENGINE_PENDING] |=> st.pend.g6[`BIT_GRAPHICS_ENGINE_PENDING];
  endproperty
  a_hw_set_gfx: assert property (p_hw_set_gfx) else $error("graphics set did not land");

  property p_evt_set;
    @(posedge hclk) disable iff (!hresetn)
    ((src_set.g6 & M6) != 16'h0000) |=> st.evt_st[2];
  endproperty
  a_evt_set: assert property (p_evt_set) else $error("group 6 event not recorded");

  property p_evt_sticky;
    @(posedge hclk) disable iff (!hresetn)
    (st.evt_st[1] && !(st.wr_pend && st.wr_addr == `OFF_EVT_CLEAR && hwdata[1])) |=> st.evt_st[1];
  endproperty
  a_evt_sticky: assert property (p_evt_sticky) else $error("group 5 event dropped without a clear");

  property p_evt_clear;
    @(posedge hclk) disable iff (!hresetn)
    (st.wr_pend && st.wr_addr == `OFF_EVT_CLEAR && hwdata[0] && (src_set.g4 & M4) == 16'h0000)
      |=> !st.evt_st[0];
  endproperty
  a_evt_clear: assert property (p_evt_clear) else $error("group 4 event not cleared");

  // per-bit check: a blocked source never requests, over all 48 positions
  for (genvar gi = 0; gi < 48; gi++)
  begin : g_req_bit
    property p_req_bit;
      @(posedge hclk) disable iff (!hresetn)
      (st.pend[gi] && !st.en[gi]) |-> !src_req[gi];
    endproperty
    a_req_bit: assert property (p_req_bit) else $error("blocked source still requests");
  end

  // main scenarios
  c_set_and_read: cover property (@(posedge hclk) disable iff (!hresetn)
    src_set.g6[`BIT_GRAPHICS_ENGINE_PENDING] ##[1:20] (rd_dphase && rd_addr == `OFF_PENDING_GROUP6));
  c_set_clear_same: cover property (@(posedge hclk) disable iff (!hresetn)
    st.wr_pend && st.wr_addr == `OFF_PENDING_GROUP5 && src_set.g5[`BIT_CAPTURE_CH9_PENDING]);
  c_irq_raise: cover property (@(posedge hclk) disable iff (!hresetn) $rose(irq));
  c_sw_force: cover property (@(posedge hclk) disable iff (!hresetn)
    st.wr_pend && st.wr_addr == `OFF_PENDING_GROUP4 && hwdata[`BIT_CHECKSUM_GEN_PENDING]);
  c_evt_clear: cover property (@(posedge hclk) disable iff (!hresetn)
    st.wr_pend && st.wr_addr == `OFF_EVT_CLEAR && (st.evt_st != 3'h0));

endmodule

// ---- common/irq_slice_defines.svh ----
// offsets, field positions, masks and reset values of the pending/enable slice
`ifndef IRQ_SLICE_DEFINES_SVH
`define IRQ_SLICE_DEFINES_SVH

// --------------------------------------------------------------------
// register byte offsets
// --------------------------------------------------------------------
`define OFF_PENDING_GROUP4  8'h00
`define OFF_PENDING_GROUP5  8'h04
`define OFF_PENDING_GROUP6  8'h08
`define OFF_ENABLE_GROUP0   8'h0c
`define OFF_ENABLE_GROUP4   8'h10
`define OFF_ENABLE_GROUP5   8'h14
`define OFF_ENABLE_GROUP6   8'h18
`define OFF_EVT_STATUS      8'h1c
`define OFF_EVT_CLEAR       8'h20
`define OFF_EVT_ENABLE      8'h24

// --------------------------------------------------------------------
// field positions, group 4
// --------------------------------------------------------------------
`define BIT_LOW_VOLTAGE_PENDING        8
`define BIT_CHECKSUM_GEN_PENDING       3
`define BIT_SERIAL_B_ERROR_PENDING     2
`define BIT_SERIAL_A_ERROR_PENDING     1

// --------------------------------------------------------------------
// field positions, group 5
// --------------------------------------------------------------------
`define BIT_CAPTURE_CH9_PENDING        13
`define BIT_COMPARE_CH9_PENDING        12
`define BIT_SYNC_SERIAL_C_EVENT_PENDING 11
`define BIT_SYNC_SERIAL_C_FAULT_PENDING 10
`define BIT_SERIAL_D_TX_PENDING        9
`define BIT_SERIAL_D_RX_PENDING        8
`define BIT_SERIAL_D_ERROR_PENDING     7
`define BIT_OTG_CONTROLLER_PENDING     6
`define BIT_TWO_WIRE_C_MASTER_PENDING  5
`define BIT_TWO_WIRE_C_SLAVE_PENDING   4
`define BIT_SERIAL_C_TX_PENDING        3
`define BIT_SERIAL_C_RX_PENDING        2
`define BIT_SERIAL_C_ERROR_PENDING     1

// --------------------------------------------------------------------
// field positions, group 6
// --------------------------------------------------------------------
`define BIT_GRAPHICS_ENGINE_PENDING    4

// --------------------------------------------------------------------
// implemented-bit masks and reset values
// --------------------------------------------------------------------
`define MASK_GROUP4         16'h010e
`define MASK_GROUP5         16'h3ffe
`define MASK_GROUP6         16'h0010
`define MASK_ENABLE_GROUP0  16'h3fef
`define RESET_FLAGS         16'h0000
`define RESET_EVT           3'h0

`endif

// ---- common/irq_slice_pkg.sv ----
// types shared by the pending/enable slice
package irq_slice_pkg;

  // one 16-bit word per flag group
  typedef struct packed {
    logic [15:0] g6;
    logic [15:0] g5;
    logic [15:0] g4;
  } grp_word_t;

  // all state of the slice
  typedef struct packed {
    grp_word_t   pend;       // pending flags
    grp_word_t   en;         // per-source enables
    logic [15:0] en0;        // enable group 0 storage
    logic [2:0]  evt_st;     // sticky group events
    logic [2:0]  evt_en;     // group event enables
    logic        wr_pend;    // write data phase due
    logic [7:0]  wr_addr;    // address of pending write
    logic [31:0] hrdata;     // read data
    logic        hreadyout;  // bus ready
    logic        hresp;      // bus response
    logic        irq;        // summary interrupt
    grp_word_t   req;        // per-source requests
  } slice_state_t;

endpackage

// ---- sim/tb.sv ----
// self-checking bench for the pending flag and enable slice over AHB-Lite
`timescale 1ns/1ps
`include "irq_slice_defines.svh"

module tb
  import irq_slice_pkg::*;
;
  // ------------------------------------------------------------------
  // signals
  // ------------------------------------------------------------------
  logic        hclk;           // 10 MHz bus clock
  logic        hresetn;        // async reset, active low
  logic        hsel;           // slave select
  logic [31:0] haddr;          // byte address
  logic [1:0]  htrans;         // transfer type
  logic        hwrite;         // write strobe
  logic [2:0]  hsize;          // word transfers only
  logic [31:0] hwdata;         // write data
  logic [31:0] hrdata;         // read data
  logic        hreadyout;      // slave ready, fed back as hready
  logic        hresp;          // response
  grp_word_t   src_set;        // hardware request pulses
  grp_word_t   src_req;        // gated requests
  logic [15:0] enable_group0;  // enable group 0 contents
  logic        irq;            // summary interrupt
  int          n_errors;       // mismatches
  int          comparisons;    // checks made
  logic [31:0] r;              // last read word
  grp_word_t   v;              // pulse pattern
  // register map, implemented bits and masks
  logic [7:0]  addrs [11] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h24, 8'h1c, 8'h20, 8'h28};
  logic [15:0] rw_exp [8] = '{`MASK_GROUP4, `MASK_GROUP5, `MASK_GROUP6, `MASK_ENABLE_GROUP0,
                              `MASK_GROUP4, `MASK_GROUP5, `MASK_GROUP6, 16'h0007};
  logic [15:0] masks [3]  = '{`MASK_GROUP4, `MASK_GROUP5, `MASK_GROUP6};

  irq_flag_enable_slice u_irq_flag_enable_slice (
    .hclk          (hclk),
    .hresetn       (hresetn),
    .hsel          (hsel),
    .haddr         (haddr),
    .htrans        (htrans),
    .hwrite        (hwrite),
    .hsize         (hsize),
    .hwdata        (hwdata),
    .hready        (hreadyout),
    .hrdata        (hrdata),
    .hreadyout     (hreadyout),
    .hresp         (hresp),
    .src_set       (src_set),
    .src_req       (src_req),
    .enable_group0 (enable_group0),
    .irq           (irq)
  );

  // ------------------------------------------------------------------
  // clock, helpers
  // ------------------------------------------------------------------
  // free running clock, 100 ns period
  always #50 hclk = ~hclk;

  // verdict and end of run
  task automatic end_sim();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // one comparison
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // reset held for four cycles
  task automatic reset_dut();
    hresetn <= 1'b0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
  endtask

  // single word transfer: address phase, then data phase
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h0, a};
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask

  // one-cycle hardware request
  task automatic pulse(input grp_word_t p);
    src_set <= p;
    @(posedge hclk);
    src_set <= '0;
  endtask

  // ------------------------------------------------------------------
  // watchdog
  // ------------------------------------------------------------------
  initial
  begin
    repeat (5000) @(posedge hclk);
    n_errors++;
    end_sim();
  end

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial
  begin
    hclk = 1'b0; hresetn = 1'b0; hsel = 1'b0; haddr = '0; htrans = 2'b00;
    hwrite = 1'b0; hsize = 3'b010; hwdata = '0; src_set = '0;
    n_errors = 0; comparisons = 0;
    reset_dut();
    // every register and the unmapped word read zero after reset
    foreach (addrs[i])
    begin
      bus(1'b0, addrs[i], 32'h0);
      chk(r, 64'h0, "reset value");
    end
    chk({src_req, enable_group0}, 64'h0, "reset outputs");
    chk({hreadyout, hresp, irq}, 64'h4, "bus outputs after reset");
    // all ones written: only implemented bits stick
    for (int i = 0; i < 8; i++)
    begin
      bus(1'b1, addrs[i], 32'hffff_ffff);
      bus(1'b0, addrs[i], 32'h0);
      chk(r, {48'h0, rw_exp[i]}, "write ones readback");
    end
    chk(enable_group0, rw_exp[3], "enable group 0 port");
    chk(src_req, {16'h0, masks[2], masks[1], masks[0]}, "forced flags gated on");
    // enables off: requests drop, flags stay
    for (int g = 0; g < 3; g++) bus(1'b1, 8'h10 + 8'(g * 4), 32'h0);
    @(posedge hclk) chk(src_req, 64'h0, "requests blocked");
    bus(1'b0, 8'h04, 32'h0);
    chk(r, {48'h0, masks[1]}, "flag kept while blocked");
    // software clears flags; unmapped word ignores a write of ones and reads zero
    for (int g = 0; g < 3; g++) bus(1'b1, 8'(g * 4), 32'h0);
    bus(1'b1, 8'h28, 32'hffff_ffff);
    bus(1'b0, 8'h28, 32'h0);
    chk(r, 64'h0, "unmapped read");
    for (int g = 0; g < 3; g++)
    begin
      bus(1'b0, 8'(g * 4), 32'h0);
      chk(r, 64'h0, "flag cleared by software");
      bus(1'b1, 8'h10 + 8'(g * 4), 32'hffff_ffff);
    end
    // each source position set by hardware alone
    for (int g = 0; g < 3; g++)
      for (int b = 0; b < 16; b++)
      begin
        v = '0;
        v[g * 16 + b] = 1'b1;
        pulse(v);
        bus(1'b0, 8'(g * 4), 32'h0);
        chk(r, {48'h0, masks[g] & (16'h1 << b)}, "hardware set position");
        chk(src_req, {16'h0, v & {masks[2], masks[1], masks[0]}}, "request follows flag");
        bus(1'b1, 8'(g * 4), 32'h0);
      end
    // hardware set and software clear in one cycle: the set wins
    v = '0;
    v[16 + `BIT_CAPTURE_CH9_PENDING] = 1'b1;
    fork
      bus(1'b1, 8'h04, 32'h0);
      begin
        @(posedge hclk);
        src_set <= v;
        @(posedge hclk);
        src_set <= '0;
      end
    join
    bus(1'b0, 8'h04, 32'h0);
    chk(r, 64'h2000, "set wins over clear");
    // event status, mask, clear and the interrupt line
    bus(1'b1, 8'h20, 32'h7);
    bus(1'b1, 8'h24, 32'h0);
    pulse({masks[2], masks[1], masks[0]});
    bus(1'b0, 8'h1c, 32'h0);
    chk(r, 64'h7, "event status sticky");
    chk(irq, 64'h0, "interrupt masked");
    bus(1'b1, 8'h24, 32'h2);
    @(posedge hclk) chk(irq, 64'h1, "interrupt raised");
    bus(1'b1, 8'h20, 32'h2);
    @(posedge hclk) chk(irq, 64'h0, "interrupt cleared");
    bus(1'b0, 8'h1c, 32'h0);
    chk(r, 64'h5, "only group 5 event cleared");
    // second reset in mid-run wipes flags
    reset_dut();
    bus(1'b0, 8'h04, 32'h0);
    chk(r, 64'h0, "flags after second reset");
    chk({src_req, enable_group0}, 64'h0, "outputs after second reset");
    chk({hreadyout, hresp, irq}, 64'h4, "bus outputs after second reset");
    end_sim();
  end
endmodule
